// file: verilog/lpwc_pkg.sv
// lpwc_pkg: shared constants and carrier types for the low-power wakeup controller.
// assumes a single 25 MHz clock domain in the always-on area.
package lpwc_pkg;

    localparam int CLOCK_PERIOD_NS     = 40;
    // exit deadlines, printed in nanoseconds
    localparam int STOP_EXIT_TIME_NS   = 3500;
    localparam int STBY_EXIT_TIME_NS   = 60000;
    // longest times round down to whole cycles
    localparam int STOP_EXIT_CYCLES    = STOP_EXIT_TIME_NS / CLOCK_PERIOD_NS;
    localparam int STBY_EXIT_CYCLES    = STBY_EXIT_TIME_NS / CLOCK_PERIOD_NS;
    // wakeup settling steps used before releasing the core; well inside both deadlines
    localparam int STOP_WAKE_STEPS     = 8;
    localparam int STBY_WAKE_STEPS     = 32;
    localparam int NUM_WAKEUP_PINS     = 3;
    localparam int NUM_EXTERNAL_INTERRUPT_LINE_LINES      = 16;

    // reset values of the clock/power enables
    localparam logic RUN_ENABLE_RESET  = 1'b1;

    typedef enum logic [4:0] {
        LPWC_RUN      = 5'h01,
        LPWC_STOP     = 5'h02,
        LPWC_STBY     = 5'h04,
        LPWC_WAKE     = 5'h08,
        LPWC_BOOT     = 5'h10
    } lpwc_state_t;

    // enables for every oscillator and supply the controller manages
    typedef struct packed {
        logic core_clock_en;
        logic pll_en;
        logic msi_en;
        logic hsi_en;
        logic hse_en;
        logic lsi_en;
        logic lse_en;
        logic reg_main_en;
        logic reg_lowpower;
        logic core_domain_on;
    } lpwc_power_t;

    // stop-mode wakeup sources
    typedef struct packed {
        logic usb;
        logic usart;
        logic i2c;
        logic low_power_uart;
        logic low_power_timer;
    } lpwc_periph_wake_t;

    // standby wakeup sources that need the real-time clock kept
    typedef struct packed {
        logic alarm_a;
        logic alarm_b;
        logic tamper;
        logic timestamp;
        logic wakeup_timer;
    } lpwc_rtc_wake_t;

endpackage : lpwc_pkg

// file: verilog/lpwc_wake_latch.sv
// lpwc_wake_latch: catches wakeup requests asynchronously and presents them synchronously.
// assumes the request bundle is already qualified; clear comes from the clocked controller.
`timescale 1ns/1ps
module lpwc_wake_latch (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // request and handshake
    input  wire logic wake_any,
    input  wire logic clear,
    output logic      wake_sync
);
    logic caught_r;
    logic meta_r;
    logic sync_r;

    // asynchronous capture so a short pulse with clocks stopped is kept [RULE_15]
    always_ff @(posedge wake_any or posedge clear) begin
        if (clear) begin
            caught_r <= 1'b0;
        end else begin
            caught_r <= 1'b1;
        end
    end

    // flushed while clear is high so a stale request cannot end the next low-power visit
    always_ff @(posedge clk) begin
        if (!resetn || clear) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= caught_r | wake_any;
            sync_r <= meta_r;
        end
    end

    // a request already high as clear falls has no edge; it is still seen as a level
    assign wake_sync = sync_r;

endmodule : lpwc_wake_latch

// file: verilog/lpwc_ctrl.sv
// lpwc_ctrl: sequences stop and standby entry and exit, and steers oscillators and supplies.
// assumes the processor requests low-power entry with a one-cycle pulse; inputs synchronous to CLOCK.
//
// Notes on behaviour
// RULE_01 - stop keeps memory and registers; no retention reset is issued in stop.
// RULE_02 - stop entry gates clocks, disables PLL, all RC and crystal oscillators; LSI and LSE stay on here when the watchdog or clock uses them.
// RULE_03 - in stop the core regulator goes to low-power mode, not off.
// RULE_04 - wakeup-capable peripherals may request the 16 MHz RC during stop.
// RULE_05 - any external interrupt line wakes stop; core resumes within 3.5 us.
// RULE_06 - line source: any pin, supply detector, comparators only with reference on.
// RULE_07 - USB, USART, I2C, low-power UART and timer events also wake stop.
// RULE_08 - standby with clock kept powers off core, PLL, fast oscillators; slow runs; here only the slow oscillator the clock or watchdog uses stays on.
// RULE_09 - standby loses all state except the always-on standby domain.
// RULE_10 - standby with clock exits within 60 us on reset, watchdog, pins, clock events.
// RULE_11 - standby without clock also stops both slow oscillators; LSI stays on here while the watchdog is enabled.
// RULE_12 - standby without clock exits only on reset pin or wakeup pin edge.
// RULE_13 - entering low power never halts the clock, watchdog or their sources; standby without clock halts the clock and LSE here.
// RULE_14 - software drives unbonded pins low as outputs; outside this block.
// RULE_15 - enabled wakeup requests are OR-ed and caught asynchronously.
`timescale 1ns/1ps
module lpwc_ctrl #(
    parameter int NUM_LINES = lpwc_pkg::NUM_EXTERNAL_INTERRUPT_LINE_LINES,
    parameter int NUM_PINS  = lpwc_pkg::NUM_WAKEUP_PINS
) (
    // clock and reset
    input  wire logic                        CLOCK,
    input  wire logic                        RESETN,
    // processor requests
    input  wire logic                        STOP_REQ,
    input  wire logic                        STANDBY_REQ,
    input  wire logic                        STANDBY_KEEP_RTC,
    // clocks that software keeps alive across low power
    input  wire logic                        RTC_SW_ENABLE,
    input  wire logic                        WDG_SW_ENABLE,
    input  wire logic                        RTC_USES_LSE,
    // external interrupt line sources and masks
    input  wire logic [NUM_LINES-1:0]        LINE_GPIO,
    input  wire logic                        SUPPLY_VOLTAGE_DETECTOR,
    input  wire logic                        COMP1_EVENT,
    input  wire logic                        COMP2_EVENT,
    input  wire logic                        VREFINT_ON,
    input  wire logic [NUM_LINES+2:0]        LINE_ENABLE,
    // peripheral wakeups
    input  wire lpwc_pkg::lpwc_periph_wake_t PERIPH_WAKE,
    input  wire logic                        PERIPH_HSI_REQ,
    // standby wakeups
    input  wire logic                        EXTERNAL_RESET_PIN_N,
    input  wire logic                        WATCHDOG_RESET,
    input  wire logic [NUM_PINS-1:0]         WAKEUP_PIN,
    input  wire logic [NUM_PINS-1:0]         WAKEUP_PIN_ENABLE,
    input  wire lpwc_pkg::lpwc_rtc_wake_t    RTC_WAKE,
    // power and clock controls
    output lpwc_pkg::lpwc_power_t            POWER,
    output logic                             RETENTION_RESET,
    output logic                             CORE_RUN,
    output logic                             WOKE_FROM_STANDBY,
    output lpwc_pkg::lpwc_state_t            STATE
);
    // step counts must fit the six-bit settling counter
    if (NUM_LINES < 1 || NUM_PINS < 1 || lpwc_pkg::STOP_WAKE_STEPS > 63 || lpwc_pkg::STBY_WAKE_STEPS > 63) begin : g_bad_params
        $error("lpwc_ctrl: line and pin counts must be at least one, step counts at most 63");
    end

    lpwc_pkg::lpwc_state_t state_r, state_nxt;
    lpwc_pkg::lpwc_power_t power_r, power_nxt;
    logic                  keep_rtc_r, keep_rtc_nxt;
    logic                  from_stby_r, from_stby_nxt;
    logic                  ret_rst_r, ret_rst_nxt;
    logic                  core_run_r, core_run_nxt;
    logic [5:0]            cnt_r, cnt_nxt;
    logic [NUM_PINS-1:0]   pin_d_r;
    logic                  wake_sync;
    logic                  latch_clear;
    logic                  stop_wake;
    logic                  stby_wake;
    logic                  wake_any;

    // comparator events count only with the reference on [RULE_06]
    logic [NUM_LINES+2:0] line_src;
    assign line_src = {COMP2_EVENT & VREFINT_ON, COMP1_EVENT & VREFINT_ON,
                       SUPPLY_VOLTAGE_DETECTOR, LINE_GPIO};

    logic [NUM_PINS-1:0] pin_rise;
    assign pin_rise = WAKEUP_PIN & ~pin_d_r & WAKEUP_PIN_ENABLE;

    // any enabled line or peripheral event ends stop [RULE_05] [RULE_07]
    assign stop_wake = (|(line_src & LINE_ENABLE)) | (|PERIPH_WAKE) | ~EXTERNAL_RESET_PIN_N;

    // clock-kept standby also wakes on watchdog and clock events [RULE_10] [RULE_12]
    assign stby_wake = ~EXTERNAL_RESET_PIN_N | (|pin_rise)
                     | (keep_rtc_r & (WATCHDOG_RESET | (|RTC_WAKE)));

    // only the source set of the present state feeds the catcher [RULE_15]
    assign wake_any = (state_r == lpwc_pkg::LPWC_STOP) ? stop_wake
                    : (state_r == lpwc_pkg::LPWC_STBY) ? stby_wake : 1'b0;
    assign latch_clear = (state_r == lpwc_pkg::LPWC_RUN);

    lpwc_wake_latch u_latch (
        .clk       (CLOCK),
        .resetn    (RESETN),
        .wake_any  (wake_any),
        .clear     (latch_clear),
        .wake_sync (wake_sync)
    );

    function automatic lpwc_pkg::lpwc_power_t run_power(input logic lse_on);
        lpwc_pkg::lpwc_power_t p;
        p = '0;
        p.core_clock_en  = 1'b1;
        p.msi_en         = 1'b1;
        p.hsi_en         = 1'b1;
        p.reg_main_en    = 1'b1;
        p.core_domain_on = 1'b1;
        p.lsi_en         = 1'b1;
        p.lse_en         = lse_on;
        return p;
    endfunction : run_power

    always_comb begin
        state_nxt     = state_r;
        power_nxt     = power_r;
        keep_rtc_nxt  = keep_rtc_r;
        from_stby_nxt = from_stby_r;
        ret_rst_nxt   = 1'b0;
        core_run_nxt  = core_run_r;
        cnt_nxt       = cnt_r;
        case (state_r)
            lpwc_pkg::LPWC_RUN: begin
                if (STANDBY_REQ) begin
                    keep_rtc_nxt = STANDBY_KEEP_RTC;
                    power_nxt    = '0;                               // [RULE_08]
                    // slow oscillators survive only for the clock or watchdog [RULE_11] [RULE_13]
                    power_nxt.lsi_en = (STANDBY_KEEP_RTC | WDG_SW_ENABLE) & (~RTC_USES_LSE | WDG_SW_ENABLE);
                    power_nxt.lse_en = STANDBY_KEEP_RTC & RTC_SW_ENABLE & RTC_USES_LSE;
                    if (!STANDBY_KEEP_RTC) begin
                        power_nxt.lsi_en = WDG_SW_ENABLE;          // [RULE_11] [RULE_13]
                    end
                    core_run_nxt = 1'b0;
                    state_nxt    = lpwc_pkg::LPWC_STBY;
                end else if (STOP_REQ) begin
                    power_nxt              = '0;                   // [RULE_02]
                    power_nxt.reg_lowpower = 1'b1;                  // [RULE_03]
                    power_nxt.core_domain_on = 1'b1;                // [RULE_01]
                    power_nxt.lsi_en       = WDG_SW_ENABLE | (RTC_SW_ENABLE & ~RTC_USES_LSE); // [RULE_13]
                    power_nxt.lse_en       = RTC_SW_ENABLE & RTC_USES_LSE;                   // [RULE_13]
                    core_run_nxt           = 1'b0;
                    state_nxt              = lpwc_pkg::LPWC_STOP;
                end
            end
            lpwc_pkg::LPWC_STOP: begin
                power_nxt.hsi_en = PERIPH_HSI_REQ;                 // [RULE_04]
                if (wake_sync) begin
                    power_nxt = run_power(power_r.lse_en);
                    cnt_nxt   = 6'(lpwc_pkg::STOP_WAKE_STEPS);
                    state_nxt = lpwc_pkg::LPWC_WAKE;
                end
            end
            lpwc_pkg::LPWC_STBY: begin
                if (wake_sync) begin
                    power_nxt     = run_power(power_r.lse_en);
                    ret_rst_nxt   = 1'b1;                         // [RULE_09]
                    from_stby_nxt = 1'b1;
                    cnt_nxt       = 6'(lpwc_pkg::STBY_WAKE_STEPS);
                    state_nxt     = lpwc_pkg::LPWC_BOOT;
                end
            end
            lpwc_pkg::LPWC_WAKE, lpwc_pkg::LPWC_BOOT: begin
                ret_rst_nxt = (state_r == lpwc_pkg::LPWC_BOOT);
                if (cnt_r == 6'h00) begin
                    ret_rst_nxt  = 1'b0;
                    core_run_nxt = 1'b1;                             // [RULE_05] [RULE_10]
                    state_nxt    = lpwc_pkg::LPWC_RUN;
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            default: begin
                state_nxt = lpwc_pkg::LPWC_RUN;
            end
        endcase
        if (state_r == lpwc_pkg::LPWC_RUN && (STOP_REQ || STANDBY_REQ)) begin
            from_stby_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state_r     <= lpwc_pkg::LPWC_RUN;
            power_r     <= run_power(lpwc_pkg::RUN_ENABLE_RESET);
            keep_rtc_r  <= 1'b0;
            from_stby_r <= 1'b0;
            ret_rst_r   <= 1'b0;
            core_run_r  <= 1'b1;
            cnt_r       <= 6'h00;
            pin_d_r     <= '0;
        end else begin
            state_r     <= state_nxt;
            power_r     <= power_nxt;
            keep_rtc_r  <= keep_rtc_nxt;
            from_stby_r <= from_stby_nxt;
            ret_rst_r   <= ret_rst_nxt;
            core_run_r  <= core_run_nxt;
            cnt_r       <= cnt_nxt;
            pin_d_r     <= WAKEUP_PIN;
        end
    end

    assign POWER             = power_r;
    assign RETENTION_RESET   = ret_rst_r;
    assign CORE_RUN          = core_run_r;
    assign WOKE_FROM_STANDBY = from_stby_r;
    assign STATE             = state_r;

endmodule : lpwc_ctrl

// file: sim/lpwc_sva.sv
// lpwc_sva: port assertions for lpwc_ctrl.
// assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module lpwc_sva #(
    parameter int NUM_LINES = lpwc_pkg::NUM_EXTERNAL_INTERRUPT_LINE_LINES
) (
    // clock and reset
    input wire logic                  CLOCK,
    input wire logic                  RESETN,
    // requests and sources
    input wire logic                  STOP_REQ,
    input wire logic                  STANDBY_REQ,
    input wire logic                  WDG_SW_ENABLE,
    input wire logic [NUM_LINES-1:0]  LINE_GPIO,
    input wire logic [NUM_LINES+2:0]  LINE_ENABLE,
    input wire logic                  PERIPH_HSI_REQ,
    input wire logic                  EXTERNAL_RESET_PIN_N,
    // controls
    input wire lpwc_pkg::lpwc_power_t POWER,
    input wire logic                  RETENTION_RESET,
    input wire logic                  CORE_RUN,
    input wire lpwc_pkg::lpwc_state_t STATE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    wire is_run  = STATE == lpwc_pkg::LPWC_RUN;
    wire is_stop = STATE == lpwc_pkg::LPWC_STOP;
    wire is_stby = STATE == lpwc_pkg::LPWC_STBY;
    localparam int STBY_LIMIT = lpwc_pkg::STBY_EXIT_CYCLES;
    wire stby_exit_req = is_stby && !EXTERNAL_RESET_PIN_N;
    // the standby deadline is too long for a delay range, so cycles are counted here
    logic [10:0] stby_wait_r;
    always_ff @(posedge CLOCK) begin
        if (!RESETN || (is_run && CORE_RUN)) begin
            stby_wait_r <= 11'h000;
        end else if ((stby_wait_r != 11'h000 || stby_exit_req) && stby_wait_r < 11'(STBY_LIMIT)) begin
            stby_wait_r <= stby_wait_r + 11'h001;
        end
    end
    sequence s_line;
        is_stop && |(LINE_GPIO & LINE_ENABLE[NUM_LINES-1:0]);
    endsequence
    sequence s_up;
        is_run && CORE_RUN;
    endsequence
    a_stop_entry: assert property (is_run && STOP_REQ && !STANDBY_REQ |=> is_stop && !CORE_RUN)
        else $error("stop not entered");
    a_stop_clocks: assert property (is_stop |-> !(POWER.core_clock_en || POWER.pll_en || POWER.msi_en || POWER.hse_en))
        else $error("clock left running in stop");
    a_stop_hsi: assert property (is_stop && $past(is_stop) |-> POWER.hsi_en == $past(PERIPH_HSI_REQ))
        else $error("fast rc does not follow peripheral request");
    a_stop_regulator: assert property (is_stop |-> POWER.reg_lowpower && POWER.core_domain_on && !RETENTION_RESET)
        else $error("stop lost core supply");
    a_stop_watchdog: assert property (is_stop && $past(is_stop) && $past(WDG_SW_ENABLE) |-> POWER.lsi_en)
        else $error("watchdog clock halted");
    a_stby_off: assert property (is_stby |-> !(POWER.core_domain_on || POWER.reg_main_en || POWER.pll_en || POWER.msi_en || POWER.hsi_en || POWER.hse_en))
        else $error("standby left core powered");
    a_stop_wake: assert property (s_line |-> ##[1:87] s_up)
        else $error("stop exit too slow");
    a_stby_wake: assert property (stby_wait_r == 11'(STBY_LIMIT) |-> s_up)
        else $error("standby exit too slow");
    a_boot_clear: assert property (STATE == lpwc_pkg::LPWC_BOOT |-> RETENTION_RESET)
        else $error("boot without state clear");
endmodule : lpwc_sva

bind lpwc_ctrl lpwc_sva #(.NUM_LINES(NUM_LINES)) i_sva (
    .CLOCK, .RESETN, .STOP_REQ, .STANDBY_REQ, .WDG_SW_ENABLE, .LINE_GPIO, .LINE_ENABLE,
    .PERIPH_HSI_REQ, .EXTERNAL_RESET_PIN_N, .POWER, .RETENTION_RESET, .CORE_RUN, .STATE
);

// file: sim/lpwc_src_model.sv
// lpwc_src_model: wakeup sources facing the controller, one event at a time.
// assumes fire is a one-cycle command; sel stays put until the next one.
`timescale 1ns/1ps
module lpwc_src_model (
    // clock and command
    input  wire logic        clk,
    input  wire logic        fire,
    input  wire logic [5:0]  sel,
    input  wire logic [2:0]  hold,
    // source lines
    output logic      [33:0] src
);
    int cnt = 0;
    initial src = '0;
    always @(posedge clk) begin
        if (fire) cnt <= hold;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // events of one to four cycles; every unused line idles low
    always @(negedge clk) begin
        src <= (cnt > 0) ? (34'h1 << sel) : '0;
    end
endmodule : lpwc_src_model

// file: sim/lpwc_ctrl_tb.sv
// lpwc_ctrl_tb: self-checking bench, every source tried in random modes.
// assumes lpwc_ctrl and lpwc_src_model; inputs change on falling edges.
`timescale 1ns/1ps
module lpwc_ctrl_tb;
    logic CLOCK = 0, RESETN = 0, stop_req = 0, stby_req = 0, keep = 0, rtc_en = 0, wdg_en = 0;
    logic uses_lse = 0, vref = 0, hsi_req = 0, fire = 0, rr_sig, core_run, woke, rr = 0;
    logic [18:0] line_en = '0;
    logic [2:0]  pin_en = '0, hold = 3'h1;
    logic [5:0]  sel = '0;
    logic [33:0] src;
    lpwc_pkg::lpwc_power_t power;
    lpwc_pkg::lpwc_state_t state;
    int seed = 94, miscompares = 0, comparisons = 0, cycles = 0;
    lpwc_src_model i_src (.clk(CLOCK), .fire(fire), .sel(sel), .hold(hold), .src(src));
    lpwc_ctrl i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .STOP_REQ(stop_req), .STANDBY_REQ(stby_req),
        .STANDBY_KEEP_RTC(keep), .RTC_SW_ENABLE(rtc_en), .WDG_SW_ENABLE(wdg_en), .RTC_USES_LSE(uses_lse),
        .LINE_GPIO(src[15:0]), .SUPPLY_VOLTAGE_DETECTOR(src[16]), .COMP1_EVENT(src[17]),
        .COMP2_EVENT(src[18]), .VREFINT_ON(vref), .LINE_ENABLE(line_en), .PERIPH_WAKE(src[23:19]),
        .PERIPH_HSI_REQ(hsi_req), .EXTERNAL_RESET_PIN_N(!src[33]), .WATCHDOG_RESET(src[32]),
        .WAKEUP_PIN(src[31:29]), .WAKEUP_PIN_ENABLE(pin_en), .RTC_WAKE(src[28:24]), .POWER(power),
        .RETENTION_RESET(rr_sig), .CORE_RUN(core_run), .WOKE_FROM_STANDBY(woke), .STATE(state));
    initial begin
        forever #20 CLOCK = ~CLOCK;
    end
    task automatic wrap_up;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // mode 0 stop, 1 standby keeping the clock, 2 standby without it
    function automatic bit wakes(int m, int s);
        if (s == 33) return 1;
        if (s >= 29 && s <= 31) return m != 0 && pin_en[s-29] === 1;
        if (m == 2) return 0;
        if (m == 1) return s >= 24;
        if (s >= 19) return 1;
        return line_en[s] === 1 && (s < 17 || vref === 1);
    endfunction : wakes
    task automatic pulse(int s, int lim, output int n);
        sel = 6'(s);
        hold = 3'(1 + ($unsigned($random(seed)) % 4));
        fire = 1;
        rr = 0;
        n = 0;
        @(negedge CLOCK);
        fire = 0;
        while (core_run !== 1 && n < lim) begin
            @(negedge CLOCK);
            n++;
            if (rr_sig === 1) rr = 1;
        end
    endtask : pulse
    task automatic op(int m, int s);
        int n;
        bit exp;
        if (m == 0 && s >= 24 && s <= 32) m = 1;
        exp = wakes(m, s);
        stop_req = (m == 0);
        stby_req = (m != 0);
        keep = (m == 1);
        wdg_en = (m == 0) && $random(seed) % 2;
        rtc_en = (m == 1) || ((m == 0) && $random(seed) % 2);
        @(negedge CLOCK);
        stop_req = 0;
        stby_req = 0;
        @(negedge CLOCK);
        chk(state, m ? lpwc_pkg::LPWC_STBY : lpwc_pkg::LPWC_STOP);
        chk(power.lsi_en | power.lse_en, wdg_en | rtc_en);
        chk(power.hsi_en, m == 0 && hsi_req);
        pulse(s, exp ? 1600 : 200, n);
        chk(core_run, exp);
        if (!exp) pulse(33, 1600, n);
        chk(n <= (m ? lpwc_pkg::STBY_EXIT_CYCLES : lpwc_pkg::STOP_EXIT_CYCLES), 1);
        chk(woke, m != 0);
        chk(rr, m != 0);
    endtask : op
    initial begin
        repeat (3) @(negedge CLOCK);
        RESETN = 1;
        for (int i = 0; i < 68; i++) begin
            line_en = 19'($random(seed));
            pin_en = 3'($random(seed));
            vref = 1'($random(seed));
            hsi_req = 1'($random(seed));
            uses_lse = 1'($random(seed));
            op($unsigned($random(seed)) % 3, i % 34);
        end
        wrap_up();
    end
endmodule : lpwc_ctrl_tb
